// *** rtl/bmx_bus_eng.sv ***
// Device port master: one registered access per request, read data passed through unregistered
`timescale 1ns/1ps
`default_nettype none
module bmx_bus_eng (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire bmx_pkg::bmx_dev_req_type req,
  output logic [11:0] dev_addr,
  output logic [31:0] dev_wdata,
  output logic dev_we,
  output logic dev_re,
  input wire logic [31:0] dev_rdata,
  output logic ack,
  output logic [31:0] rsp_data
);
  logic rd_ack_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dev_addr <= 12'h0;
      dev_wdata <= 32'h0;
      dev_we <= 1'b0;
      dev_re <= 1'b0;
      rd_ack_q <= 1'b0;
    end else begin
      dev_we <= req_valid && req.we;
      dev_re <= req_valid && req.re && !req.we;
      rd_ack_q <= dev_re;
      if (req_valid) begin
        dev_addr <= req.addr;
        dev_wdata <= req.wdata;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  assign ack = dev_we || rd_ack_q;
  assign rsp_data = dev_rdata;

  a_strobe_exclusive: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(dev_we && dev_re))
    else $error("write and read strobe high together");
endmodule
`default_nettype wire

// *** rtl/bmx_ctrl.sv ***
// Host-side controller that sequences the bignum exponent accelerator
//
// Behaviour
// - Wait for init-done before any device access
// - Lengths 512..4096 bits, one length per job
// - Montgomery constant is always one word
// - Software precomputes constant and squared-radix residue
// - Exponent: length, operands, constant, then go
// - Write 1 clears done flag before next start
// - Modular multiply: length, operands, constant, then go
// - Second factor into base memory, second round
// - Plain multiply only for 512..2048 bit factors
// - Plain multiply length code is doubled plus nine
// - Zero words of extended factors must be written
`timescale 1ns/1ps
`default_nettype none
module bmx_ctrl #(
  parameter int POLL_CYC = bmx_pkg::POLL_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [31:0] host_rdata,
  output logic [11:0] dev_addr,
  output logic [31:0] dev_wdata,
  output logic dev_we,
  output logic dev_re,
  input wire logic [31:0] dev_rdata,
  input wire logic done_irq,
  output logic accel_power_down
);
  // --------------------------------------------------------------------
  // Types and helpers
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OFF = 4'h0, S_INIT = 4'h1, S_IDLE = 4'h3, S_MODE = 4'h2,
    S_MCONST = 4'h6, S_ZERO = 4'h7, S_START = 4'h5, S_WAIT = 4'h4,
    S_CLR = 4'hc, S_MEM = 4'hd
  } bmx_state_type;

  // Digit index to byte address, least significant digit lowest
  function automatic logic [11:0] mem_addr(input logic [1:0] sel,
                                           input logic [6:0] idx);
    logic [11:0] base;
    base = bmx_pkg::DEV_MEM_BASE;
    case (sel)
      2'h1: base = bmx_pkg::DEV_MEM_EXP;
      2'h2: base = bmx_pkg::DEV_MEM_MOD;
      2'h3: base = bmx_pkg::DEV_MEM_RES;
      default: base = bmx_pkg::DEV_MEM_BASE;
    endcase
    return base + {3'h0, idx, 2'h0};
  endfunction

  // Length code written to the device for each kind of job
  function automatic logic [31:0] mode_value(input bmx_pkg::bmx_op_type op,
                                             input logic [2:0] len);
    if (op == bmx_pkg::OP_MUL) begin
      return {28'h0, {len, 1'b1} + bmx_pkg::MUL_MODE_OFS};
    end
    return {29'h0, len};
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  bmx_state_type state_q;
  bmx_pkg::bmx_op_type op_q;
  bmx_pkg::bmx_dev_req_type req_d;
  logic pwr_q, init_done_q, done_q, err_q, half_q;
  logic [2:0] len_q;
  logic [31:0] mconst_q, wbuf_q, rdbuf_q, host_rdata_q;
  logic [1:0] memsel_q;
  logic [6:0] memidx_q;
  logic [7:0] ptr_q, nwords;
  logic zphase_q, issued_q, req_valid_q, pd_q;
  logic irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
  logic ack, tick, poll_run, issue, done_set, err_set;
  logic [31:0] rsp_data;
  logic wr_cmd, wr_stat, wr_memwr, wr_memrd;
  bmx_pkg::bmx_op_type cmd_op;
  logic cmd_ok;

  assign nwords = 8'(({5'h0, len_q} + 8'h1) * 8'(bmx_pkg::WORDS_PER_STEP));
  assign wr_cmd = host_wr && host_addr == bmx_pkg::H_CMD;
  assign wr_stat = host_wr && host_addr == bmx_pkg::H_STATUS;
  assign wr_memwr = host_wr && host_addr == bmx_pkg::H_MEMWR;
  assign wr_memrd = host_wr && host_addr == bmx_pkg::H_MEMRD;
  assign cmd_op = bmx_pkg::bmx_op_type'(host_wdata[2:0]);

  // Jobs are taken only when idle; bad lengths or a lone second round fail
  always_comb begin
    cmd_ok = 1'b0;
    if (state_q == S_IDLE && pwr_q) begin
      if (wr_memwr || wr_memrd) begin
        cmd_ok = 1'b1;
      end else if (wr_cmd) begin
        case (cmd_op)
          bmx_pkg::OP_EXP: cmd_ok = 1'b1;
          bmx_pkg::OP_MM1: cmd_ok = 1'b1;
          bmx_pkg::OP_MM2: cmd_ok = half_q;
          bmx_pkg::OP_MUL: cmd_ok = len_q <= bmx_pkg::MUL_MAX_LEN;
          default: cmd_ok = 1'b0;
        endcase
      end
    end
  end
  assign err_set = (wr_cmd || wr_memwr || wr_memrd) && !cmd_ok;

  // --------------------------------------------------------------------
  // Interrupt pin synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      irq_s3_q <= 1'b0;
      irq_lvl_q <= 1'b0;
    end else begin
      irq_s1_q <= done_irq;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (irq_s2_q == irq_s3_q) begin
        irq_lvl_q <= irq_s3_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // Software-visible configuration
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= 1'b0;
      len_q <= bmx_pkg::LEN_RST;
      mconst_q <= bmx_pkg::MCONST_RST;
      memsel_q <= 2'h0;
      memidx_q <= 7'h0;
      wbuf_q <= 32'h0;
      pd_q <= 1'b1;
    end else begin
      pd_q <= !pwr_q;
      if (host_wr && host_addr == bmx_pkg::H_CTRL) begin
        pwr_q <= host_wdata[bmx_pkg::CTRL_PWR_BIT];
        // Length may not change under a running job
        if (state_q == S_IDLE || state_q == S_OFF) begin
          len_q <= host_wdata[bmx_pkg::CTRL_LEN_LSB +: 3];
        end
      end
      if (host_wr && host_addr == bmx_pkg::H_MCONST) begin
        mconst_q <= host_wdata;
      end
      if (host_wr && host_addr == bmx_pkg::H_MEMPTR) begin
        memsel_q <= host_wdata[bmx_pkg::PTR_SEL_LSB +: 2];
        memidx_q <= host_wdata[6:0];
      end else if (state_q == S_MEM && ack) begin
        memidx_q <= memidx_q + 7'h1;
      end
      if (wr_memwr && cmd_ok) begin
        wbuf_q <= host_wdata;
      end
    end
  end
  assign accel_power_down = pd_q;

  // --------------------------------------------------------------------
  // Sticky flags: hardware set wins over a software clear
  // --------------------------------------------------------------------
  assign done_set = state_q == S_CLR && ack;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (done_set) begin
        done_q <= 1'b1;
      end else if (wr_stat && host_wdata[bmx_pkg::ST_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      if (err_set) begin
        err_q <= 1'b1;
      end else if (wr_stat && host_wdata[bmx_pkg::ST_ERR_BIT]) begin
        err_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Device access requests
  // --------------------------------------------------------------------
  always_comb begin
    req_d = '0;
    case (state_q)
      S_INIT: begin
        req_d.re = 1'b1;
        req_d.addr = bmx_pkg::DEV_INIT_DONE;
      end
      S_MODE: begin
        req_d.we = 1'b1;
        req_d.addr = (op_q == bmx_pkg::OP_EXP) ?
                     bmx_pkg::DEV_EXP_LENGTH_SEL : bmx_pkg::DEV_MUL_LENGTH_SEL;
        req_d.wdata = mode_value(op_q, len_q);
      end
      S_MCONST: begin
        req_d.we = 1'b1;
        req_d.addr = bmx_pkg::DEV_MONTGOMERY_CONST;
        req_d.wdata = mconst_q;
      end
      S_ZERO: begin
        req_d.we = 1'b1;
        // Upper half of the base digits, lower half of the result digits
        req_d.addr = zphase_q ? mem_addr(2'h3, ptr_q[6:0]) :
                     mem_addr(2'h0, 7'(nwords + ptr_q));
      end
      S_START: begin
        req_d.we = 1'b1;
        req_d.addr = (op_q == bmx_pkg::OP_EXP) ?
                     bmx_pkg::DEV_EXP_GO : bmx_pkg::DEV_MUL_GO;
        req_d.wdata = 32'h1;
      end
      S_WAIT: begin
        req_d.re = 1'b1;
        req_d.addr = bmx_pkg::DEV_DONE_FLAG;
      end
      S_CLR: begin
        req_d.we = 1'b1;
        req_d.addr = bmx_pkg::DEV_DONE_FLAG;
        req_d.wdata = 32'h1;
      end
      S_MEM: begin
        req_d.we = op_q == bmx_pkg::OP_MWR;
        req_d.re = op_q == bmx_pkg::OP_MRD;
        req_d.addr = mem_addr(memsel_q, memidx_q);
        req_d.wdata = wbuf_q;
      end
      default: req_d = '0;
    endcase
  end

  // Polling states wait for a tick; the irq pin shortens the wait in S_WAIT only
  assign poll_run = state_q == S_INIT || state_q == S_WAIT;
  assign issue = !issued_q && state_q != S_OFF && state_q != S_IDLE &&
                 (!poll_run || tick || (state_q == S_WAIT && irq_lvl_q));

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_OFF;
      op_q <= bmx_pkg::OP_NONE;
      init_done_q <= 1'b0;
      half_q <= 1'b0;
      issued_q <= 1'b0;
      req_valid_q <= 1'b0;
      ptr_q <= 8'h0;
      zphase_q <= 1'b0;
    end else if (!pwr_q) begin
      state_q <= S_OFF;
      init_done_q <= 1'b0;
      half_q <= 1'b0;
      issued_q <= 1'b0;
      req_valid_q <= 1'b0;
    end else begin
      req_valid_q <= issue;
      if (issue) begin
        issued_q <= 1'b1;
      end else if (ack) begin
        issued_q <= 1'b0;
      end
      case (state_q)
        S_OFF: state_q <= S_INIT;
        S_INIT: if (ack && rsp_data[0]) begin
          init_done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_IDLE: if (cmd_ok) begin
          ptr_q <= 8'h0;
          zphase_q <= 1'b0;
          if (wr_memwr) begin
            op_q <= bmx_pkg::OP_MWR;
            state_q <= S_MEM;
          end else if (wr_memrd) begin
            op_q <= bmx_pkg::OP_MRD;
            state_q <= S_MEM;
          end else if (cmd_op == bmx_pkg::OP_MM2) begin
            // Length, modulus and constant still stand from round one
            op_q <= cmd_op;
            state_q <= S_START;
          end else begin
            op_q <= cmd_op;
            state_q <= S_MODE;
          end
        end
        S_MODE: if (ack) begin
          state_q <= (op_q == bmx_pkg::OP_MUL) ? S_ZERO : S_MCONST;
        end
        S_MCONST: if (ack) begin
          state_q <= S_START;
        end
        S_ZERO: if (ack) begin
          zphase_q <= !zphase_q;
          if (zphase_q) begin
            ptr_q <= ptr_q + 8'h1;
            if (ptr_q == nwords - 8'h1) begin
              state_q <= S_START;
            end
          end
        end
        S_START: if (ack) begin
          state_q <= S_WAIT;
        end
        S_WAIT: if (ack && rsp_data[0]) begin
          state_q <= S_CLR;
        end
        S_CLR: if (ack) begin
          half_q <= op_q == bmx_pkg::OP_MM1;
          state_q <= S_IDLE;
        end
        S_MEM: if (ack) begin
          state_q <= S_IDLE;
        end
        default: state_q <= S_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdbuf_q <= 32'h0;
    end else if (state_q == S_MEM && ack && op_q == bmx_pkg::OP_MRD) begin
      rdbuf_q <= rsp_data;
    end
  end

  // --------------------------------------------------------------------
  // Host read port: data stand in the cycle after the strobe
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata_q <= 32'h0;
    end else if (host_rd) begin
      if (host_addr == bmx_pkg::H_CTRL) begin
        host_rdata_q <= {28'h0, len_q, pwr_q};
      end else if (host_addr == bmx_pkg::H_STATUS) begin
        host_rdata_q <= {27'h0, half_q, err_q, done_q,
                         state_q != S_IDLE, init_done_q};
      end else if (host_addr == bmx_pkg::H_MCONST) begin
        host_rdata_q <= mconst_q;
      end else if (host_addr == bmx_pkg::H_MEMPTR) begin
        host_rdata_q <= {23'h0, memsel_q, memidx_q};
      end else if (host_addr == bmx_pkg::H_MEMRD) begin
        host_rdata_q <= rdbuf_q;
      end else begin
        host_rdata_q <= 32'h0;
      end
    end
  end
  assign host_rdata = host_rdata_q;

  bmx_tick #(
    .DIV(POLL_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(poll_run && !issued_q),
    .tick(tick)
  );

  bmx_bus_eng u_eng (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .req_valid(req_valid_q),
    .req(req_d),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_we(dev_we),
    .dev_re(dev_re),
    .dev_rdata(dev_rdata),
    .ack(ack),
    .rsp_data(rsp_data)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_write_after_init: assert property (@(posedge sys_clk) disable iff (!rstn)
    dev_we |-> init_done_q)
    else $error("device written before init done");

  a_pd_blocks_init: assert property (@(posedge sys_clk) disable iff (!rstn)
    accel_power_down |-> !init_done_q)
    else $error("init done shown while powered down");

  a_done_after_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dev_we && dev_addr == bmx_pkg::DEV_DONE_FLAG) |=> done_q)
    else $error("done flag not set after device flag clear");

  a_go_writes_one: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dev_we && (dev_addr == bmx_pkg::DEV_EXP_GO ||
     dev_addr == bmx_pkg::DEV_MUL_GO)) |-> dev_wdata == 32'h1)
    else $error("go register written with other than 1");

  a_mul_code_range: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dev_we && dev_addr == bmx_pkg::DEV_MUL_LENGTH_SEL &&
     op_q == bmx_pkg::OP_MUL) |-> (dev_wdata[0] && dev_wdata >= 32'h9 &&
     dev_wdata <= 32'hf))
    else $error("plain multiply length code out of range");

  a_const_one_word: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dev_we && dev_addr == bmx_pkg::DEV_MONTGOMERY_CONST) |->
    dev_wdata == mconst_q)
    else $error("constant write differs from held word");

  a_zero_fill_data: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == S_ZERO && dev_we) |-> dev_wdata == 32'h0)
    else $error("zero fill wrote nonzero data");

  a_go_then_poll: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == S_START && ack && pwr_q) |=> state_q == S_WAIT ##1
    (!dev_we)[*2])
    else $error("no wait after go");
endmodule
`default_nettype wire

// *** rtl/bmx_pkg.sv ***
// Package: shared constants and types of the bignum accelerator controller
package bmx_pkg;

  // --------------------------------------------------------------------
  // Accelerator register map (byte offsets on the device port)
  // --------------------------------------------------------------------
  localparam logic [11:0] DEV_MONTGOMERY_CONST = 12'h800;
  localparam logic [11:0] DEV_EXP_LENGTH_SEL = 12'h804;
  localparam logic [11:0] DEV_EXP_GO = 12'h808;
  localparam logic [11:0] DEV_MUL_LENGTH_SEL = 12'h80c;
  localparam logic [11:0] DEV_MUL_GO = 12'h810;
  localparam logic [11:0] DEV_DONE_FLAG = 12'h814;
  localparam logic [11:0] DEV_INIT_DONE = 12'h818;
  // Operand memory bases: base, exponent, modulus, result
  localparam logic [11:0] DEV_MEM_BASE = 12'h000;
  localparam logic [11:0] DEV_MEM_EXP = 12'h200;
  localparam logic [11:0] DEV_MEM_MOD = 12'h400;
  localparam logic [11:0] DEV_MEM_RES = 12'h600;
  localparam int MEM_WORDS = 128;
  localparam int WORDS_PER_STEP = 16;

  // --------------------------------------------------------------------
  // Controller register map (byte offsets on the host port)
  // --------------------------------------------------------------------
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_CMD = 8'h04;
  localparam logic [7:0] H_STATUS = 8'h08;
  localparam logic [7:0] H_MCONST = 8'h0c;
  localparam logic [7:0] H_MEMPTR = 8'h10;
  localparam logic [7:0] H_MEMWR = 8'h14;
  localparam logic [7:0] H_MEMRD = 8'h18;
  // Field positions
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_LEN_LSB = 1;
  localparam int ST_INIT_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_HALF_BIT = 4;
  localparam int PTR_SEL_LSB = 7;
  // Reset values and limits
  localparam logic [2:0] LEN_RST = 3'h0;
  localparam logic [31:0] MCONST_RST = 32'h0;
  localparam logic [2:0] MUL_MAX_LEN = 3'h3;
  localparam logic [3:0] MUL_MODE_OFS = 4'h8;

  // --------------------------------------------------------------------
  // Commands and timing
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_EXP = 3'h1, OP_MM1 = 3'h2, OP_MM2 = 3'h3,
    OP_MUL = 3'h4, OP_MWR = 3'h5, OP_MRD = 3'h6
  } bmx_op_type;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POLL_NS = 1000;
  localparam int POLL_CYC = (POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [31:0] wdata;
  } bmx_dev_req_type;

endpackage

// *** rtl/bmx_tick.sv ***
// Poll rate divider: one-cycle enable pulse every DIV cycles while running
`timescale 1ns/1ps
`default_nettype none
module bmx_tick #(
  parameter int DIV = 50
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0;
      tick <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h1;
      tick <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
    tick |=> !tick)
    else $error("poll tick lasted more than one cycle");
endmodule
`default_nettype wire

// *** sim/bmx_ctrl_tb.sv ***
// Testbench: host register sequences against the accelerator model
`timescale 1ns/1ps
`default_nettype none
module bmx_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic [31:0] host_wdata = 32'h0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [31:0] host_rdata, dev_rdata, dev_wdata, rd;
  logic [11:0] dev_addr;
  logic dev_we, dev_re, done_irq, accel_power_down;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  bmx_ctrl #(.POLL_CYC(2)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_we(dev_we), .dev_re(dev_re),
    .dev_rdata(dev_rdata), .done_irq(done_irq),
    .accel_power_down(accel_power_down));
  bmx_dev_model dev (.sys_clk(sys_clk), .accel_power_down(accel_power_down),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we),
    .dev_re(dev_re), .dev_rdata(dev_rdata), .done_irq(done_irq));
  // ------------------------------------------------------------------
  // Host access and checking
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge sys_clk);
    host_wr <= 1'b0;
  endtask
  // A memory word write keeps the controller busy for three cycles
  task automatic hwm(input logic [31:0] d);
    hw(bmx_pkg::H_MEMWR, d);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic hr(input logic [7:0] a);
    @(posedge sys_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    #1 rd = host_rdata;
  endtask
  // Bounded poll of one status bit
  task automatic wait_st(input int b);
    for (int i = 0; i < 200; i++) begin
      hr(bmx_pkg::H_STATUS);
      if (rd[b] === 1'b1) break;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    hr(bmx_pkg::H_STATUS);
    // Not idle, hence busy, until powered and initialised
    chk(rd, 32'h2);
    chk({31'h0, accel_power_down}, 32'h1);
    hw(bmx_pkg::H_CTRL, 32'h3);
    wait_st(bmx_pkg::ST_INIT_BIT);
    chk(rd & 32'h1, 32'h1);
    chk({31'h0, dev.init_q}, 32'h1);
    hw(bmx_pkg::H_MEMPTR, 32'h0);
    hwm(32'h11);
    hwm(32'h22);
    hw(bmx_pkg::H_MEMPTR, 32'h28);
    hwm(32'hdead);
    hw(bmx_pkg::H_MEMPTR, 32'h185);
    hwm(32'h55);
    repeat (6) @(posedge sys_clk);
    hr(bmx_pkg::H_STATUS);
    chk(rd, 32'h1);
    chk(dev.mem[0], 32'h11);
    chk(dev.mem[40], 32'hdead);
    chk(dev.mem[1], 32'h22);
    chk(dev.mem[389], 32'h55);
    hw(bmx_pkg::H_MEMPTR, 32'h185);
    hw(bmx_pkg::H_MEMRD, 32'h0);
    repeat (6) @(posedge sys_clk);
    hr(bmx_pkg::H_MEMRD);
    chk(rd, 32'h55);
    hw(bmx_pkg::H_MCONST, 32'h1234abcd);
    hw(bmx_pkg::H_CMD, 32'h1);
    hr(bmx_pkg::H_STATUS);
    chk(rd & 32'h2, 32'h2);
    wait_st(bmx_pkg::ST_DONE_BIT);
    chk(rd & 32'h6, 32'h4);
    chk({29'h0, dev.exp_len_q}, 32'h1);
    chk(dev.mconst_q, 32'h1234abcd);
    chk({31'h0, dev.done_q}, 32'h0);
    hw(bmx_pkg::H_STATUS, 32'h4);
    hr(bmx_pkg::H_STATUS);
    chk(rd & 32'h4, 32'h0);
    hw(bmx_pkg::H_CMD, 32'h2);
    wait_st(bmx_pkg::ST_DONE_BIT);
    chk({28'h0, dev.mul_len_q}, 32'h1);
    hw(bmx_pkg::H_STATUS, 32'h4);
    hw(bmx_pkg::H_CMD, 32'h3);
    wait_st(bmx_pkg::ST_DONE_BIT);
    chk(dev.mconst_q, 32'h1234abcd);
    hw(bmx_pkg::H_STATUS, 32'h4);
    hw(bmx_pkg::H_CMD, 32'h4);
    wait_st(bmx_pkg::ST_DONE_BIT);
    chk({28'h0, dev.mul_len_q}, 32'hb);
    chk(dev.mem[40], 32'h0);
    chk(dev.mem[389], 32'h0);
    hw(bmx_pkg::H_STATUS, 32'h4);
    hw(bmx_pkg::H_CTRL, 32'h9);
    hw(bmx_pkg::H_CMD, 32'h4);
    hr(bmx_pkg::H_STATUS);
    chk(rd & 32'ha, 32'h8);
    hr(8'h1c);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

// *** sim/bmx_dev_model.sv ***
// Behavioural model of the bignum accelerator seen on the device port
`timescale 1ns/1ps
`default_nettype none
module bmx_dev_model #(
  parameter int OP_CYC = 24
) (
  input wire logic sys_clk,
  input wire logic accel_power_down,
  input wire logic [11:0] dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic dev_we,
  input wire logic dev_re,
  output logic [31:0] dev_rdata,
  output logic done_irq
);
  logic [31:0] mem [0:511];
  logic [31:0] mconst_q, rdata_q;
  logic [2:0] exp_len_q;
  logic [3:0] mul_len_q;
  logic [7:0] clr_q;
  logic [5:0] cnt_q;
  logic init_q, done_q, busy_q, is_exp_q, rv_q;
  // Outside its read cycle the data bus shows garbage, not the last word
  assign dev_rdata = rv_q ? rdata_q : ~rdata_q;
  assign done_irq = done_q;
  always @(posedge sys_clk or posedge accel_power_down) begin
    rv_q <= 1'b0;
    if (accel_power_down) begin
      {init_q, done_q, busy_q, clr_q} <= '0;
    end else begin
      if (!init_q) begin
        for (int m = 0; m < 4; m++) mem[m * 128 + clr_q] <= 32'h0;
        clr_q <= clr_q + 8'h1;
        init_q <= (clr_q == 8'h7f);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 6'h1;
        if (cnt_q == 6'h0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          // Exponent trashes the first base word; exponent and modulus are kept
          if (is_exp_q) mem[0] <= ~mem[0];
        end
      end
      if (dev_re) begin
        rv_q <= 1'b1;
        case (dev_addr)
          12'h800: rdata_q <= mconst_q;
          12'h804: rdata_q <= {29'h0, exp_len_q};
          12'h80c: rdata_q <= {28'h0, mul_len_q};
          12'h814: rdata_q <= {31'h0, done_q};
          12'h818: rdata_q <= {31'h0, init_q};
          default: rdata_q <= mem[dev_addr[10:2]];
        endcase
      end
      if (dev_we) begin
        case (dev_addr)
          12'h800: mconst_q <= dev_wdata;
          12'h804: exp_len_q <= dev_wdata[2:0];
          12'h80c: mul_len_q <= dev_wdata[3:0];
          12'h814: if (dev_wdata[0]) done_q <= 1'b0;
          12'h808, 12'h810: if (dev_wdata[0] && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= OP_CYC[5:0];
            is_exp_q <= dev_addr[3];
          end
          default: if (!dev_addr[11]) mem[dev_addr[10:2]] <= dev_wdata;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
